// >>> common/serial_port_pkg.sv
// constants of the serial peripheral port
// assumes one 200 MHz clock and 32-bit bus words
package serial_port_pkg;
   // register indices, byte address is four times the index
   localparam logic [9:0] IDX_DATA   = 10'h03C;
   localparam logic [9:0] IDX_CFG    = 10'h03D;
   localparam logic [9:0] IDX_STAT   = 10'h03E;
   localparam logic [9:0] IDX_ICLR   = 10'h03F;
   localparam logic [9:0] IDX_IEN    = 10'h040;
   localparam logic [9:0] IDX_PIN    = 10'h041;
   // config fields
   localparam int         CFG_SWAP   = 7;
   localparam int         CFG_LSB    = 6;
   localparam int         CFG_MODE   = 4;
   localparam int         CFG_CLOCK_IDLE_POLARITY   = 3;
   localparam int         CFG_CLOCK_SAMPLE_PHASE   = 2;
   localparam int         CFG_RATE   = 0;
   localparam logic [1:0] MODE_OFF   = 2'h0;
   localparam logic [1:0] MODE_MSTR  = 2'h1;
   localparam logic [1:0] MODE_SLV   = 2'h2;
   // master clock divisors
   localparam logic [6:0] DIV_SEL0   = 7'h06;
   localparam logic [6:0] DIV_SEL1   = 7'h0C;
   localparam logic [6:0] DIV_SEL2   = 7'h30;
   localparam logic [6:0] DIV_SEL3   = 7'h60;
   // byte framing
   localparam logic [3:0] LAST_EDGE  = 4'hF;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam logic [3:0] LAST_BIT   = 4'h7;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // line numbering
   localparam int         LINE_CLK   = 0;
   localparam int         LINE_MOUT  = 1;
   localparam int         LINE_MIN   = 2;
   localparam int         LINE_SEL   = 3;
   // pin control fields
   localparam int         PINC_FUNC  = 0;
   localparam int         PINC_OE    = 4;
   localparam int         PINC_DAT   = 8;
   // status bits
   localparam int         ST_RX      = 0;
   localparam int         ST_TXE     = 1;
endpackage : serial_port_pkg

// >>> common/rate_tick_if.sv
// rate selection and half-period tick between port and divider
// assumes both ends on the same clock
interface rate_tick_if;
   logic [1:0] rate;
   logic       run;
   logic       tick;
   modport gen  (input rate, input run, output tick);
   modport sink (output rate, output run, input tick);
endinterface : rate_tick_if

// >>> logic/serial_rate_div.sv
// master serial clock half-period tick generator
// assumes run is held for the whole master transfer
module serial_rate_div (
   input  logic        clk,
   input  logic        rst,
   rate_tick_if.gen    t
);
   typedef struct packed {
      logic [6:0] cnt;
      logic       tick;
   } div_t;

   div_t       r;
   div_t       n;
   logic [6:0] half;

   always_comb begin
      n = r;
      case (t.rate)
         2'h0:    half = serial_port_pkg::DIV_SEL0 >> 1;
         2'h1:    half = serial_port_pkg::DIV_SEL1 >> 1;
         2'h2:    half = serial_port_pkg::DIV_SEL2 >> 1;
         default: half = serial_port_pkg::DIV_SEL3 >> 1;
      endcase
      if (!t.run) begin
         n.cnt  = 7'h00;
         n.tick = 1'b0;
      end else if (r.cnt == half - 7'h01) begin
         n.cnt  = 7'h00;
         n.tick = 1'b1;
      end else begin
         n.cnt  = r.cnt + 7'h01;
         n.tick = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign t.tick = r.tick;
endmodule : serial_rate_div

// >>> logic/line_sync.sv
// two-stage synchroniser for the four serial lines
// assumes inputs are asynchronous pin levels
module line_sync (
   input  logic       clk,
   input  logic       rst,
   input  logic [3:0] async_in,
   output logic [3:0] sync_out
);
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
   } sync_t;

   sync_t r;
   sync_t n;

   always_comb begin
      n    = r;
      n.s1 = async_in;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign sync_out = r.s2;
endmodule : line_sync

// >>> logic/serial_peripheral_port.sv
// serial peripheral port: registers, shift engine, pin muxing
// assumes an AHB-Lite master and pins sampled through line_sync
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R1] shift core is timed by serial clock edges, not the processor clock; here it shifts on clk when a serial clock edge is detected
// [R2] link uses clock, select and two one-way data lines
// [R3] data read gives receive buffer; write fills transmit holding register
// [R4] interrupt on received byte and on transmit holding register empty
// [R5] firmware services buffers within seven serial clocks of an interrupt
// [R6] swap bit exchanges master-out and master-in line roles
// [R7] bit order bit picks LSB first when set, MSB first when clear
// [R8] role field: 00 off, 01 master, 10 slave, 11 reserved
// [R9] polarity bit sets serial clock idle level
// [R10] phase bit picks the sampling edge
// [R11] master clock divides core clock by 6, 12, 48 or 96
// [R12] serial logic sets clock and data pin directions from the role
// [R13] firmware sets select pin direction itself
// [R14] function bit hands pin drive to serial logic, else port bits; here port bits also drive in the off and reserved roles
// [R15] phase clear samples leading edge; phase set samples trailing edge
// [R16] slave shifts only while select is low, eight bits per byte
//
// Decided for this implementation: the AHB-Lite slave port.
module serial_peripheral_port (
   input  logic        clk,
   input  logic        rst,
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic        hreadyout,
   output logic [31:0] hrdata,
   output logic        hresp,
   input  logic [3:0]  line_in,
   output logic [3:0]  line_out,
   output logic [3:0]  line_oe,
   output logic        irq
);
   typedef struct packed {
      logic [7:0]  cfg;
      logic [7:0]  tx_hold;
      logic        tx_full;
      logic [7:0]  rx_buf;
      logic [7:0]  tx_sh;
      logic [7:0]  rx_sh;
      logic [3:0]  bit_cnt;
      logic [3:0]  edge_cnt;
      logic        busy;
      logic        sclk;
      logic        sclk_prev;
      logic [1:0]  stat;
      logic [1:0]  ien;
      logic [11:0] pinc;
      logic        wr_pend;
      logic [9:0]  wr_idx;
      logic [31:0] rdata;
      logic [3:0]  pin_oe;
      logic [3:0]  pin_out;
   } port_t;

   port_t       r;
   port_t       n;
   logic [3:0]  sync_in;
   logic [1:0]  mode;
   logic        master;
   logic        slave;
   logic        clock_idle_polarity;
   logic        clock_sample_phase;
   logic        lsb;
   logic        out_on_mout;
   logic        rx_bit;
   logic        sclk_s;
   logic        sel_s;
   logic        lead;
   logic        trail;
   logic        sample;
   logic        change;
   logic        accept;
   logic        do_load;
   logic        rx_done;
   logic [7:0]  rx_next;
   logic [9:0]  a_idx;
   logic [3:0]  ser_oe;
   logic [3:0]  ser_out;
   logic        data_oe;
   logic        tx_bit;
   logic        nxt_master;
   logic        nxt_slave;
   logic        nxt_out_mout;

   rate_tick_if t ();

   ////////////////////////////////////////////////////////////////////////
   // submodules
   line_sync u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (line_in),
      .sync_out (sync_in)
   );

   serial_rate_div u_div (
      .clk (clk),
      .rst (rst),
      .t   (t.gen)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode
   assign mode        = r.cfg[serial_port_pkg::CFG_MODE +: 2];
   assign master      = (mode == serial_port_pkg::MODE_MSTR); // R8
   assign slave       = (mode == serial_port_pkg::MODE_SLV); // R8
   assign clock_idle_polarity        = r.cfg[serial_port_pkg::CFG_CLOCK_IDLE_POLARITY];
   assign clock_sample_phase        = r.cfg[serial_port_pkg::CFG_CLOCK_SAMPLE_PHASE];
   assign lsb         = r.cfg[serial_port_pkg::CFG_LSB];
   assign out_on_mout = master ^ r.cfg[serial_port_pkg::CFG_SWAP]; // R6
   assign rx_bit      = out_on_mout ? sync_in[serial_port_pkg::LINE_MIN]
                                    : sync_in[serial_port_pkg::LINE_MOUT]; // R6
   assign sclk_s      = sync_in[serial_port_pkg::LINE_CLK];
   assign sel_s       = sync_in[serial_port_pkg::LINE_SEL];
   assign t.rate      = r.cfg[serial_port_pkg::CFG_RATE +: 2]; // R11
   assign t.run       = master & r.busy; // R11

   // leading edge leaves the idle level
   always_comb begin
      if (master) begin
         lead  = r.busy & t.tick & (r.sclk == clock_idle_polarity); // R9
         trail = r.busy & t.tick & (r.sclk != clock_idle_polarity);
      end else begin
         lead  = slave & r.busy & ~sel_s & (sclk_s != r.sclk_prev)
                 & (r.sclk_prev == clock_idle_polarity); // R16
         trail = slave & r.busy & ~sel_s & (sclk_s != r.sclk_prev)
                 & (r.sclk_prev != clock_idle_polarity); // R16
      end
   end

   assign sample  = clock_sample_phase ? trail : lead; // R10 R15
   assign change  = clock_sample_phase ? lead : trail; // R10 R15
   assign rx_next = lsb ? {rx_bit, r.rx_sh[7:1]} : {r.rx_sh[6:0], rx_bit}; // R7
   assign rx_done = sample & (r.bit_cnt == serial_port_pkg::LAST_BIT);
   assign accept  = hsel & hready & htrans[1]
                    & (hsize == serial_port_pkg::HSIZE_WORD);
   assign a_idx   = haddr[11:2];

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      n           = r;
      do_load     = 1'b0;
      n.sclk_prev = sclk_s;
      // bus address phase
      n.wr_pend   = accept & hwrite;
      n.wr_idx    = a_idx;
      if (accept && !hwrite) begin
         case (a_idx)
            serial_port_pkg::IDX_DATA: n.rdata = {24'h000000, r.rx_buf}; // R3
            serial_port_pkg::IDX_CFG:  n.rdata = {24'h000000, r.cfg};
            serial_port_pkg::IDX_STAT: n.rdata = {28'h0000000, r.tx_full,
                                                  r.busy, r.stat};
            serial_port_pkg::IDX_IEN:  n.rdata = {30'h00000000, r.ien};
            serial_port_pkg::IDX_PIN:  n.rdata = {20'h00000, r.pinc};
            default:                   n.rdata = 32'h00000000;
         endcase
      end
      // bus data phase, clear before the engine sets
      if (r.wr_pend) begin
         case (r.wr_idx)
            serial_port_pkg::IDX_CFG:  n.cfg  = hwdata[7:0];
            serial_port_pkg::IDX_ICLR: n.stat = r.stat & ~hwdata[1:0];
            serial_port_pkg::IDX_IEN:  n.ien  = hwdata[1:0];
            serial_port_pkg::IDX_PIN:  n.pinc = hwdata[11:0];
            default: ;
         endcase
      end
      // shift engine
      if (!master && !slave) begin
         n.busy     = 1'b0; // R8
         n.sclk     = clock_idle_polarity; // R9
         n.bit_cnt  = 4'h0;
         n.edge_cnt = 4'h0;
      end else if (!r.busy) begin
         n.sclk = clock_idle_polarity; // R9
         if ((master && r.tx_full) || (slave && !sel_s)) begin
            n.busy     = 1'b1;
            n.edge_cnt = 4'h0;
            do_load    = 1'b1;
         end
      end else if (slave && sel_s) begin
         n.busy = 1'b0; // R16
      end else begin
         if (master && t.tick) begin
            n.sclk     = ~r.sclk; // R11
            n.edge_cnt = r.edge_cnt + 4'h1;
            if (r.edge_cnt == serial_port_pkg::LAST_EDGE) begin
               n.busy = 1'b0;
               n.sclk = clock_idle_polarity;
            end
         end
         if (sample) begin
            n.rx_sh   = rx_next; // R1
            n.bit_cnt = r.bit_cnt + 4'h1;
            if (rx_done) begin
               n.rx_buf             = rx_next; // R3
               n.stat[serial_port_pkg::ST_RX] = 1'b1; // R4
            end
         end else if (change) begin
            if (r.bit_cnt == serial_port_pkg::BYTE_BITS) begin
               do_load = slave; // R16
            end else if (r.bit_cnt != 4'h0) begin
               n.tx_sh = lsb ? {1'b0, r.tx_sh[7:1]} : {r.tx_sh[6:0], 1'b0}; // R7
            end
         end
      end
      if (do_load) begin
         n.bit_cnt = 4'h0;
         n.tx_sh   = r.tx_full ? r.tx_hold : serial_port_pkg::RESET_BYTE;
         if (r.tx_full) begin
            n.tx_full                       = 1'b0;
            n.stat[serial_port_pkg::ST_TXE] = 1'b1; // R4
         end
      end
      // a data write lands after any load in the same cycle
      if (r.wr_pend && (r.wr_idx == serial_port_pkg::IDX_DATA)) begin
         n.tx_hold = hwdata[7:0]; // R3
         n.tx_full = 1'b1; // R3
      end
      // pin drive from the next state
      // role and swap of the next config, so pins and config move together
      nxt_master   = (n.cfg[serial_port_pkg::CFG_MODE +: 2] == serial_port_pkg::MODE_MSTR);
      nxt_slave    = (n.cfg[serial_port_pkg::CFG_MODE +: 2] == serial_port_pkg::MODE_SLV);
      nxt_out_mout = nxt_master ^ n.cfg[serial_port_pkg::CFG_SWAP]; // R6
      tx_bit  = lsb ? n.tx_sh[0] : n.tx_sh[7];
      data_oe = nxt_master | (nxt_slave & n.busy);
      ser_oe  = 4'h0;
      ser_out = 4'h0;
      ser_oe[serial_port_pkg::LINE_CLK]   = nxt_master; // R12
      ser_oe[serial_port_pkg::LINE_MOUT]  = data_oe & nxt_out_mout; // R12
      ser_oe[serial_port_pkg::LINE_MIN]   = data_oe & ~nxt_out_mout; // R12
      ser_oe[serial_port_pkg::LINE_SEL]   = n.pinc[serial_port_pkg::PINC_OE
                                                   + serial_port_pkg::LINE_SEL]; // R13
      ser_out[serial_port_pkg::LINE_CLK]  = n.sclk;
      ser_out[serial_port_pkg::LINE_MOUT] = tx_bit;
      ser_out[serial_port_pkg::LINE_MIN]  = tx_bit;
      ser_out[serial_port_pkg::LINE_SEL]  = nxt_master ? ~n.busy
                                            : n.pinc[serial_port_pkg::PINC_DAT
                                                     + serial_port_pkg::LINE_SEL];
      for (int i = 0; i < 4; i++) begin
         if ((nxt_master || nxt_slave) && n.pinc[serial_port_pkg::PINC_FUNC + i]) begin
            n.pin_oe[i]  = ser_oe[i]; // R14
            n.pin_out[i] = ser_out[i]; // R14
         end else begin
            n.pin_oe[i]  = n.pinc[serial_port_pkg::PINC_OE + i]; // R14
            n.pin_out[i] = n.pinc[serial_port_pkg::PINC_DAT + i]; // R14
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = r.rdata;
   assign line_out  = r.pin_out; // R2
   assign line_oe   = r.pin_oe; // R2
   assign irq       = |(r.stat & r.ien); // R4

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_data_wr;
      (r.wr_pend && r.wr_idx == serial_port_pkg::IDX_DATA)
      |=> r.tx_full && r.tx_hold == $past(hwdata[7:0]);
   endproperty
   a_data_wr: assert property (p_data_wr) else $error("data write not held"); // R3

   property p_rx_irq;
      rx_done && r.ien[serial_port_pkg::ST_RX] |=> irq ##1 irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("rx interrupt missing"); // R4

   property p_tick_gap;
      t.tick |=> !t.tick [*2];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick too fast"); // R11

   property p_master_len;
      $rose(r.busy) && master |=> r.busy [*8];
   endproperty
   a_master_len: assert property (p_master_len) else $error("master byte short"); // R11

   property p_idle_level;
      master && !r.busy |=> r.sclk == $past(clock_idle_polarity);
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("idle level wrong"); // R9

   property p_off;
      mode == serial_port_pkg::MODE_OFF |=> !r.busy && !t.run;
   endproperty
   a_off: assert property (p_off) else $error("off mode still busy"); // R8

   property p_sel_high;
      slave && sel_s |=> !r.busy;
   endproperty
   a_sel_high: assert property (p_sel_high) else $error("slave runs unselected"); // R16

   property p_swap;
      master && !r.cfg[serial_port_pkg::CFG_SWAP]
      && r.pinc[serial_port_pkg::PINC_FUNC + serial_port_pkg::LINE_MOUT]
      && r.pinc[serial_port_pkg::PINC_FUNC + serial_port_pkg::LINE_MIN]
      |-> line_oe[serial_port_pkg::LINE_MOUT] && !line_oe[serial_port_pkg::LINE_MIN];
   endproperty
   a_swap: assert property (p_swap) else $error("data line role wrong"); // R6

   property p_gpio;
      !r.pinc[serial_port_pkg::PINC_FUNC + serial_port_pkg::LINE_CLK]
      |-> line_oe[serial_port_pkg::LINE_CLK]
          == r.pinc[serial_port_pkg::PINC_OE + serial_port_pkg::LINE_CLK];
   endproperty
   a_gpio: assert property (p_gpio) else $error("port bit not driving pin"); // R14

   c_master_byte: cover property (master && rx_done);
   c_slave_byte:  cover property (slave && rx_done);
   c_irq_rise:    cover property ($rose(irq));
endmodule : serial_peripheral_port

// >>> verification/serial_slave_model.sv
// external serial slave facing the port in its master role
// reacts to serial clock edges as they occur, not on the fast clock; leading edge samples, trailing changes
module serial_slave_model (
   input  wire logic       clk,
   input  wire logic       sclk,
   input  wire logic       sel_n,
   input  wire logic       mosi,
   input  wire logic       lsb,
   input  wire logic       clock_idle_polarity,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       idle_q;
   logic       s_q;
   logic [7:0] sh;
   initial begin
      idle_q = 1'b0;
      s_q = 1'b0;
      sh = 8'h00;
      rx_byte = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // released line flips so a stale level is never taken for data
   always @(posedge clk) begin
      idle_q <= ~idle_q;
   end
   assign miso = sel_n ? idle_q : (lsb ? sh[0] : sh[7]);
   // react at the serial clock edge itself, as a real slave does
   always @(sel_n or sclk or tx_byte) begin
      if (sel_n) begin
         sh <= tx_byte;
      end else if (sclk !== s_q) begin
         if (sclk ^ clock_idle_polarity) begin
            rx_byte <= lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
         end else begin
            sh <= lsb ? sh >> 1 : sh << 1;
         end
      end
      s_q <= sclk;
   end
endmodule : serial_slave_model

// >>> verification/tb_serial_peripheral_port.sv
// bench for the serial peripheral port over AHB-Lite
// assumes pull-ups on undriven lines and one slave model
module tb_serial_peripheral_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, hsel, hwrite, hreadyout, hresp, irq;
   logic        miso, lsb, swp, clock_idle_polarity;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  line_in, line_out, line_oe, far;
   logic [7:0]  ptx, prx;
   int          bad_count, n_compared;
   always #2.5 clk = ~clk;
   always_comb begin
      far = 4'hF;
      if (swp) far[1] = miso;
      else far[2] = miso;
   end
   assign line_in = (line_oe & line_out) | (~line_oe & far);
   serial_peripheral_port dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .irq(irq));
   serial_slave_model partner (.clk(clk), .sclk(line_in[0]), .sel_n(line_in[3]),
      .mosi(swp ? line_in[2] : line_in[1]), .lsb(lsb), .clock_idle_polarity(clock_idle_polarity), .tx_byte(ptx),
      .miso(miso), .rx_byte(prx));
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wait_ready();
      int i;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (hreadyout === 1'b1) break;
      end
      if (i == 100) begin
         check("hready wait", 1, 0);
         give_verdict();
      end
   endtask : wait_ready
   task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h00000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= serial_port_pkg::HSIZE_WORD;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      bus(1'b1, idx, wd, d);
   endtask : wr
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] v;
      logic [9:0]  idx [6] = '{serial_port_pkg::IDX_DATA, serial_port_pkg::IDX_CFG,
         serial_port_pkg::IDX_STAT, serial_port_pkg::IDX_IEN, serial_port_pkg::IDX_PIN,
         10'h050};
      wr(10'h050, 32'hFFFFFFFF);
      foreach (idx[k]) begin
         bus(1'b0, idx[k], 32'h0, v);
         check("reset value", v, 32'h0);
      end
      check("reset oe", line_oe, 4'h0);
      check("reset irq", irq, 1'b0);
      check("hresp", hresp, 1'b0);
   endtask : t_reset
   task automatic t_fallback();
      logic [31:0] v;
      wr(serial_port_pkg::IDX_PIN, 32'hF);
      wr(serial_port_pkg::IDX_CFG, 32'hFF);
      bus(1'b0, serial_port_pkg::IDX_CFG, 32'h0, v);
      check("config", v, 32'hFF);
      tick(4);
      check("reserved role oe", line_oe, 4'h0);
      wr(serial_port_pkg::IDX_CFG, 32'h0);
      wr(serial_port_pkg::IDX_PIN, 32'hA5F);
      tick(4);
      check("off role oe", line_oe, 4'h5);
      wr(serial_port_pkg::IDX_PIN, 32'hA50);
      tick(4);
      check("port oe", line_oe, 4'h5);
      check("port out", line_out, 4'hA);
   endtask : t_fallback
   task automatic t_xfer(input logic [1:0] rate, input logic l, input logic s,
                         input logic p, input logic [7:0] tx, input logic [7:0] pv);
      logic [31:0] v;
      logic [6:0]  d;
      logic        old;
      int          i;
      int          n;
      d = rate == 2'h0 ? serial_port_pkg::DIV_SEL0 : rate == 2'h1 ? serial_port_pkg::DIV_SEL1 :
          rate == 2'h2 ? serial_port_pkg::DIV_SEL2 : serial_port_pkg::DIV_SEL3;
      lsb <= l;
      swp <= s;
      clock_idle_polarity <= p;
      ptx <= pv;
      wr(serial_port_pkg::IDX_PIN, 32'h8F);
      wr(serial_port_pkg::IDX_ICLR, 32'h3);
      wr(serial_port_pkg::IDX_IEN, 32'h3);
      wr(serial_port_pkg::IDX_CFG, {24'h0, s, l, serial_port_pkg::MODE_MSTR, p, 1'b0, rate});
      tick(4);
      check("idle clock", line_out[0], p);
      check("idle select", line_out[3], 1'b1);
      wr(serial_port_pkg::IDX_DATA, {24'h0, tx});
      old = line_out[0];
      for (i = 0; i < 300 && line_out[0] === old; i++) @(posedge clk);
      old = line_out[0];
      for (n = 0; n < 300 && line_out[0] === old; n++) @(posedge clk);
      check("half period", n, d / 2);
      check("out line oe", line_oe[s ? 2 : 1], 1'b1);
      check("in line oe", line_oe[s ? 1 : 2], 1'b0);
      check("clock oe", line_oe[0], 1'b1);
      check("select active", line_out[3], 1'b0);
      for (i = 0; i < 400; i++) begin
         bus(1'b0, serial_port_pkg::IDX_STAT, 32'h0, v);
         if (v[serial_port_pkg::ST_RX] === 1'b1) break;
      end
      check("rx ready", v[serial_port_pkg::ST_RX], 1'b1);
      check("tx empty", v[serial_port_pkg::ST_TXE], 1'b1);
      check("irq on", irq, 1'b1);
      bus(1'b0, serial_port_pkg::IDX_DATA, 32'h0, v);
      check("rx byte", v, {24'h0, pv});
      for (i = 0; i < 400 && line_out[3] !== 1'b1; i++) @(posedge clk);
      tick(4);
      check("far rx byte", prx, tx);
      wr(serial_port_pkg::IDX_IEN, 32'h0);
      tick(1);
      check("irq masked", irq, 1'b0);
      wr(serial_port_pkg::IDX_ICLR, 32'h3);
      wr(serial_port_pkg::IDX_IEN, 32'h3);
      bus(1'b0, serial_port_pkg::IDX_STAT, 32'h0, v);
      check("status cleared", v[1:0], 2'h0);
      check("irq cleared", irq, 1'b0);
   endtask : t_xfer
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      lsb = 1'b0;
      swp = 1'b0;
      clock_idle_polarity = 1'b0;
      ptx = 8'h00;
      bad_count = 0;
      n_compared = 0;
      tick(2);
      rst <= 1'b0;
      t_reset();
      t_fallback();
      t_xfer(2'h0, 1'b0, 1'b0, 1'b0, 8'hA5, 8'h3C);
      t_xfer(2'h1, 1'b1, 1'b0, 1'b1, 8'h81, 8'h6E);
      t_xfer(2'h2, 1'b0, 1'b1, 1'b0, 8'h1F, 8'hC2);
      t_xfer(2'h3, 1'b1, 1'b0, 1'b1, 8'h5A, 8'h07);
      give_verdict();
   end
endmodule : tb_serial_peripheral_port
